/* include/sis_cfg.svh */
// Purpose: Constants for the stack and interrupt sequencer
// Assumes: Single core clock, 25 MHz
// Notes: Included by the package and the design file
`ifndef SIS_CFG_SVH
`define SIS_CFG_SVH
`define SIS_SP_RESET 8'h00
`define SIS_SPH_VALUE 8'h00
`define SIS_SP_ONE 8'h01
`define SIS_SP_TWO 8'h02
`define SIS_PC_W 10
`define SIS_PC_RESET 10'h000
`define SIS_RESP_CYC 3'h4
`define SIS_WAKE_CYC 3'h4
`define SIS_INTERRUPT_EXIT_OP_CYC 3'h4
`define SIS_CNT_ONE 3'h1
`define SIS_NSRC 8
`endif

/* include/sis_pkg.sv */
// Purpose: Types for the stack and interrupt sequencer
// Assumes: sis_cfg.svh constants
// Notes: State and command carriers
`include "sis_cfg.svh"
package sis_pkg;
  typedef enum logic [2:0] {
    SIS_RUN,
    SIS_WAKE,
    SIS_ENTRY,
    SIS_EXIT
  } sis_state_t;

  // One instruction-flow command per cycle from the core
  typedef struct packed {
    logic push1;
    logic pop1;
    logic call;
    logic ret;
    logic interrupt_exit_op;
    logic interrupt_unmask_op;
    logic cli;
    logic sp_wr;
    logic [7:0] sp_wdata;
    logic flag_wr;
    logic [`SIS_NSRC-1:0] flag_wdata;
    logic [`SIS_NSRC-1:0] enable;
    logic insn_done;
    logic sleeping;
  } sis_cmd_t;

  typedef struct packed {
    sis_state_t st;
    logic [2:0] cnt;
    logic [7:0] sp;
    logic gie;
    logic hold;
    logic [`SIS_NSRC-1:0] flags;
    logic [`SIS_NSRC-1:0] lvl_s1;
    logic [`SIS_NSRC-1:0] lvl_s2;
    logic [`SIS_NSRC-1:0] evt_s1;
    logic [`SIS_NSRC-1:0] evt_s2;
    logic [`SIS_NSRC-1:0] evt_s3;
    logic [2:0] vec;
    logic vec_go;
    logic busy;
    logic [`SIS_PC_W-1:0] ret_pc;
  } sis_state_s_t;
endpackage

/* logic/sis_sequencer.sv */
// Purpose: Stack pointer and interrupt entry/exit sequencing
// Assumes: Core drives one command per cycle; flag-type events are edges
// Notes: Lower source index = lower vector = higher priority
// Operation
// - push one byte decrements pointer by one
// - call or interrupt decrements pointer by two
// - pop one byte increments pointer by one
// - return ops increment pointer by two
// - high byte reads zero, low byte writable
// - take only with individual and global enable
// - lowest vector wins, request zero first
// - entry clears global enable
// - flag cleared when vectoring to handler
// - writing one clears flag
// - masked events held as pending flags
// - level sources request only while present
// - one instruction runs after interrupt return
// - status flags never saved automatically
// - disable op blocks same-cycle interrupts
// - instruction after enable op runs first
// - response takes four cycles, pc pushed
// - multi-cycle instruction completes first
// - wake from sleep adds four cycles
// - interrupt exit takes four cycles
// - pushed program counter is ten bits
`timescale 1ns/1ps
`include "sis_cfg.svh"
module sis_sequencer #(
  parameter int NSRC = `SIS_NSRC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Core instruction flow
  input wire sis_pkg::sis_cmd_t cmd_in,
  input wire logic [`SIS_PC_W-1:0] pc_in,
  // Peripheral sources
  input wire logic [NSRC-1:0] flag_event_in,
  input wire logic [NSRC-1:0] level_req_in,
  input wire logic [NSRC-1:0] is_level_in,
  // Outputs
  output logic [7:0] stack_pointer_low_out,
  output logic [7:0] stack_pointer_high_out,
  output logic global_enable_out,
  output logic [NSRC-1:0] flags_out,
  output logic vector_go_out,
  output logic [2:0] vector_index_out,
  output logic seq_busy_out,
  output logic [`SIS_PC_W-1:0] saved_pc_out
);
  sis_pkg::sis_state_s_t s_q, s_d;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] evt_edge;
  logic take;
  logic [2:0] win;

  // ----------------------------------------
  // Request gathering
  // ----------------------------------------
  always_comb begin
    evt_edge = s_q.evt_s2 & ~s_q.evt_s3;
    // Level sources bypass flags; vanished conditions never request
    req = (s_q.flags & ~is_level_in) | (s_q.lvl_s2 & is_level_in);
    req = req & cmd_in.enable;
    win = 3'h0;
    // Scan high to low so the lowest index wins
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        win = 3'(i);
      end
    end
    // Disable op blocks in its own cycle; hold covers post-enable/post-exit
    take = (|req) && s_q.gie && !cmd_in.cli && !cmd_in.interrupt_unmask_op && !s_q.hold
           && cmd_in.insn_done;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.lvl_s1 = level_req_in;
    s_d.lvl_s2 = s_q.lvl_s1;
    s_d.evt_s1 = flag_event_in;
    s_d.evt_s2 = s_q.evt_s1;
    s_d.evt_s3 = s_q.evt_s2;
    s_d.vec_go = 1'b0;
    if (cmd_in.insn_done) begin
      s_d.hold = 1'b0;
    end
    if (cmd_in.flag_wr) begin
      s_d.flags = s_d.flags & ~cmd_in.flag_wdata;
    end
    case (s_q.st)
      sis_pkg::SIS_RUN: begin
        if (cmd_in.push1) begin
          s_d.sp = s_q.sp - `SIS_SP_ONE;
        end else if (cmd_in.pop1) begin
          s_d.sp = s_q.sp + `SIS_SP_ONE;
        end else if (cmd_in.call) begin
          s_d.sp = s_q.sp - `SIS_SP_TWO;
        end else if (cmd_in.ret) begin
          s_d.sp = s_q.sp + `SIS_SP_TWO;
        end else if (cmd_in.sp_wr) begin
          s_d.sp = cmd_in.sp_wdata;
        end
        if (cmd_in.cli) begin
          s_d.gie = 1'b0;
        end else if (cmd_in.interrupt_unmask_op) begin
          s_d.gie = 1'b1;
          s_d.hold = 1'b1;
        end
        if (cmd_in.interrupt_exit_op) begin
          s_d.st = sis_pkg::SIS_EXIT;
          s_d.cnt = `SIS_INTERRUPT_EXIT_OP_CYC - `SIS_CNT_ONE;
          s_d.busy = 1'b1;
        end else if (take) begin
          s_d.vec = win;
          s_d.gie = 1'b0;
          s_d.ret_pc = pc_in;
          s_d.flags[win] = 1'b0;
          s_d.busy = 1'b1;
          if (cmd_in.sleeping) begin
            s_d.st = sis_pkg::SIS_WAKE;
            s_d.cnt = `SIS_WAKE_CYC - `SIS_CNT_ONE;
          end else begin
            s_d.st = sis_pkg::SIS_ENTRY;
            s_d.cnt = `SIS_RESP_CYC - `SIS_CNT_ONE;
          end
        end
      end
      sis_pkg::SIS_WAKE: begin
        s_d.cnt = s_q.cnt - `SIS_CNT_ONE;
        if (s_q.cnt == 3'h0) begin
          s_d.st = sis_pkg::SIS_ENTRY;
          s_d.cnt = `SIS_RESP_CYC - `SIS_CNT_ONE;
        end
      end
      sis_pkg::SIS_ENTRY: begin
        s_d.cnt = s_q.cnt - `SIS_CNT_ONE;
        if (s_q.cnt == 3'h0) begin
          // Two pc bytes pushed over the response window
          s_d.sp = s_q.sp - `SIS_SP_TWO;
          s_d.st = sis_pkg::SIS_RUN;
          s_d.vec_go = 1'b1;
          s_d.busy = 1'b0;
        end
      end
      sis_pkg::SIS_EXIT: begin
        s_d.cnt = s_q.cnt - `SIS_CNT_ONE;
        if (s_q.cnt == 3'h0) begin
          // Status flags other than enable are left alone
          s_d.sp = s_q.sp + `SIS_SP_TWO;
          s_d.gie = 1'b1;
          s_d.hold = 1'b1;
          s_d.st = sis_pkg::SIS_RUN;
          s_d.busy = 1'b0;
        end
      end
      default: begin
        s_d.st = sis_pkg::SIS_RUN;
      end
    endcase
    // Set wins over software clear and hardware clear
    for (int i = 0; i < NSRC; i++) begin
      if (evt_edge[i] && !is_level_in[i]) begin
        s_d.flags[i] = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.st <= sis_pkg::SIS_RUN;
      s_q.sp <= `SIS_SP_RESET;
      s_q.ret_pc <= `SIS_PC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      stack_pointer_high_out <= `SIS_SPH_VALUE;
    end else begin
      stack_pointer_high_out <= `SIS_SPH_VALUE;
    end
  end
  assign stack_pointer_low_out = s_q.sp;
  assign global_enable_out = s_q.gie;
  assign flags_out = s_q.flags;
  assign vector_go_out = s_q.vec_go;
  assign vector_index_out = s_q.vec;
  assign seq_busy_out = s_q.busy;
  assign saved_pc_out = s_q.ret_pc;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_push_dec_one: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && cmd_in.push1 && !cmd_in.interrupt_exit_op |=> s_q.sp == $past(s_q.sp) - 8'h01)
    else $error("push did not decrement by one");
  a_pop_inc_one: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && !cmd_in.push1 && cmd_in.pop1 |=> s_q.sp == $past(s_q.sp) + 8'h01)
    else $error("pop did not increment by one");
  a_cli_blocks_take: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && cmd_in.cli |=> s_q.st != sis_pkg::SIS_ENTRY && s_q.st != sis_pkg::SIS_WAKE)
    else $error("interrupt taken with disable op");
  a_entry_four_cyc: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN ##1 s_q.st == sis_pkg::SIS_ENTRY |-> ##4 s_q.vec_go)
    else $error("vector not issued after four cycles");
  a_entry_clears_gie: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_ENTRY |-> !s_q.gie)
    else $error("global enable set during entry");
  a_exit_sets_gie: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_EXIT && s_q.cnt == 3'h0 |=> s_q.gie && s_q.hold && s_q.sp == $past(s_q.sp) + 8'h02)
    else $error("exit did not restore enable and pointer");
  a_sei_defers: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && cmd_in.interrupt_unmask_op && !cmd_in.cli && !cmd_in.interrupt_exit_op |=> s_q.hold)
    else $error("enable op did not defer");
  a_take_needs_en: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && !s_q.gie |=> s_q.st != sis_pkg::SIS_ENTRY && s_q.st != sis_pkg::SIS_WAKE)
    else $error("interrupt taken while globally disabled");

  // Call moves the pointer by a whole return address
  a_call_dec_two: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && !cmd_in.push1 && !cmd_in.pop1 && cmd_in.call
    |=> s_q.sp == $past(s_q.sp) - `SIS_SP_TWO)
    else $error("call did not decrement by two");

  // Subroutine return gives the two bytes back
  a_ret_inc_two: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && !cmd_in.push1 && !cmd_in.pop1 && !cmd_in.call && cmd_in.ret
    |=> s_q.sp == $past(s_q.sp) + `SIS_SP_TWO)
    else $error("return did not increment by two");

  // Software load of the low byte, lowest command priority
  a_ptr_write_loads: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && cmd_in.sp_wr && !(cmd_in.push1 || cmd_in.pop1 || cmd_in.call || cmd_in.ret)
    |=> s_q.sp == $past(cmd_in.sp_wdata))
    else $error("pointer write did not load");

  // No individual enable, no entry whatever the flags say
  a_needs_ind_en: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && cmd_in.enable == '0
    |=> s_q.st != sis_pkg::SIS_ENTRY && s_q.st != sis_pkg::SIS_WAKE)
    else $error("interrupt taken with no individual enable");

  // Nothing below the winner may be requesting
  a_lowest_index_wins: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && !cmd_in.interrupt_exit_op && take
    |-> req[win] && (req & ~({NSRC{1'b1}} << win)) == '0)
    else $error("lower vector was passed over");

  // Served flag drops unless a fresh event lands on it
  a_take_clears_flag: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && !cmd_in.interrupt_exit_op && take && !evt_edge[win]
    |=> !s_q.flags[$past(win)])
    else $error("served flag still pending");

  // Ones in a flag write clear the flag
  a_write_one_clears: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cmd_in.flag_wr
    |=> (s_q.flags & $past(cmd_in.flag_wdata & ~evt_edge)) == '0)
    else $error("flag write did not clear");

  // An edge always lands in its flag, masked or not
  a_event_sets_flag: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (evt_edge & ~is_level_in) != '0
    |=> (s_q.flags & $past(evt_edge & ~is_level_in)) == $past(evt_edge & ~is_level_in))
    else $error("event edge lost");

  // After exit the interrupted code gets one instruction
  a_exit_one_insn: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_EXIT && s_q.cnt == 3'h0
    |=> s_q.st == sis_pkg::SIS_RUN ##1 (s_q.st != sis_pkg::SIS_ENTRY && s_q.st != sis_pkg::SIS_WAKE))
    else $error("interrupt taken straight after exit");

  // The instruction after the enable op runs first
  a_sei_next_insn: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && cmd_in.interrupt_unmask_op && !cmd_in.cli && !cmd_in.interrupt_exit_op
    |=> s_q.st == sis_pkg::SIS_RUN ##1 (s_q.st != sis_pkg::SIS_ENTRY && s_q.st != sis_pkg::SIS_WAKE))
    else $error("interrupt taken straight after enable op");

  // Both pc bytes accounted for as the vector starts
  a_entry_pushes_pc: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_ENTRY && s_q.cnt == 3'h0
    |=> s_q.vec_go && s_q.sp == $past(s_q.sp) - `SIS_SP_TWO)
    else $error("entry end without push and vector");

  // A multi-cycle instruction is never cut short
  a_multi_cycle_waits: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && !cmd_in.insn_done && !cmd_in.interrupt_exit_op |=> s_q.st == sis_pkg::SIS_RUN)
    else $error("interrupt cut a multi-cycle instruction");

  // Sleep wake adds four cycles ahead of the normal entry
  a_wake_eight_cyc: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN ##1 s_q.st == sis_pkg::SIS_WAKE
    |-> s_q.st == sis_pkg::SIS_WAKE [*4] ##1 s_q.st == sis_pkg::SIS_ENTRY [*4] ##1 s_q.vec_go)
    else $error("wake entry not eight cycles");

  // Exit holds off the enable for its whole four cycles
  a_exit_four_cyc: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && cmd_in.interrupt_exit_op
    |=> s_q.st == sis_pkg::SIS_EXIT [*4] ##1 (s_q.st == sis_pkg::SIS_RUN && s_q.gie))
    else $error("exit not four cycles");

  // Return address is the pc of the take cycle
  a_pc_captured: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_q.st == sis_pkg::SIS_RUN && !cmd_in.interrupt_exit_op && take |=> s_q.ret_pc == $past(pc_in))
    else $error("return address not captured");

  // Reset leaves pointer, enable and flags clear
  a_reset_clears_ptr: assert property (@(posedge core_clk_in)
    rst_in |=> s_q.sp == `SIS_SP_RESET && !s_q.gie && s_q.flags == '0)
    else $error("reset did not clear state");
endmodule

/* test/sis_sources.sv */
// Purpose: Peripheral source model for the sequencer bench
// Assumes: Bench asks for events with one-cycle fire pulses
// Notes: Events are stretched so the input synchroniser sees them
`timescale 1ns/1ps
module sis_sources (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Requests from the bench
  input wire logic [7:0] fire_in,
  input wire logic [7:0] level_in,
  // Lines into the sequencer
  output logic [7:0] flag_event_out,
  output logic [7:0] level_req_out
);
  logic [1:0] hold_q [8];
  // Three-cycle event pulse, long enough for a two-flop sync
  always_ff @(posedge core_clk_in) begin
    for (int i = 0; i < 8; i++) begin
      if (rst_in) hold_q[i] <= 2'h0;
      else if (fire_in[i]) hold_q[i] <= 2'h3;
      else if (hold_q[i] != 2'h0) hold_q[i] <= hold_q[i] - 2'h1;
    end
  end
  // Event level while stretched; level requests pass straight on
  always_comb begin
    for (int i = 0; i < 8; i++) flag_event_out[i] = (hold_q[i] != 2'h0);
  end
  assign level_req_out = level_in;
endmodule

/* test/sis_sequencer_bench.sv */
// Purpose: Self-checking bench for the stack and interrupt sequencer
// Assumes: Inputs change at the falling edge; core reports single-cycle insns except in the multi-cycle insn test
// Notes: Source 1 is level type, the rest flag type
`timescale 1ns/1ps
module sis_sequencer_bench;
  logic core_clk_in, rst_in, gie, vgo, busy;
  sis_pkg::sis_cmd_t cmd;
  logic [9:0] pc, spc;
  logic [7:0] fire, lvl, ev, lq, stack_pointer_low, stack_pointer_high, flags;
  logic [2:0] vidx;
  int fail_count, checks_done, cyc;
  sis_sequencer i_sis_sequencer (.core_clk_in(core_clk_in), .rst_in(rst_in), .cmd_in(cmd), .pc_in(pc),
    .flag_event_in(ev), .level_req_in(lq), .is_level_in(8'h02), .stack_pointer_low_out(stack_pointer_low),
    .stack_pointer_high_out(stack_pointer_high), .global_enable_out(gie), .flags_out(flags), .vector_go_out(vgo),
    .vector_index_out(vidx), .seq_busy_out(busy), .saved_pc_out(spc));
  sis_sources i_sis_sources (.core_clk_in(core_clk_in), .rst_in(rst_in), .fire_in(fire), .level_in(lvl),
    .flag_event_out(ev), .level_req_out(lq));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // One-cycle command pulse; bit 8 flag write, 7 pointer write .. 0 push
  task automatic op(input logic [8:0] which, input logic [7:0] d);
    @(negedge core_clk_in);
    {cmd.flag_wr, cmd.sp_wr, cmd.cli, cmd.interrupt_unmask_op, cmd.interrupt_exit_op, cmd.ret, cmd.call, cmd.pop1, cmd.push1} = which;
    cmd.sp_wdata = d;
    cmd.flag_wdata = d;
    @(negedge core_clk_in);
    {cmd.flag_wr, cmd.sp_wr, cmd.cli, cmd.interrupt_unmask_op, cmd.interrupt_exit_op, cmd.ret, cmd.call, cmd.pop1, cmd.push1} = 9'h000;
  endtask
  task automatic fire_src(input logic [7:0] m);
    @(negedge core_clk_in);
    fire = m;
    @(negedge core_clk_in);
    fire = 8'h00;
    repeat (6) @(negedge core_clk_in);
  endtask
  // Entry: wait for the take, then count edges to the vector pulse
  task automatic take(input logic [2:0] src, input int lat);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 30) begin
      @(negedge core_clk_in);
      n++;
    end
    chk(n, 2, "take delay");
    chk(gie, 1'b0, "enable on entry");
    chk(flags[src], 1'b0, "flag on entry");
    n = 0;
    while (vgo !== 1'b1 && n < 30) begin
      @(negedge core_clk_in);
      n++;
    end
    chk(n, lat, "entry latency");
    chk(vidx, src, "vector");
    chk(stack_pointer_low, 8'h7e, "pointer after entry");
    chk(spc, pc, "saved pc");
  endtask
  // Exit: enable and pointer change only on the fourth edge
  task automatic leave();
    op(9'h010, 8'h00);
    repeat (3) @(negedge core_clk_in);
    chk(gie, 1'b0, "enable mid exit");
    @(negedge core_clk_in);
    chk({gie, stack_pointer_low}, 9'h180, "after exit");
  endtask
  task automatic results();
    $display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  // Cut a hang short well past the expected run length
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    rst_in = 1'b1;
    cmd = '0;
    cmd.insn_done = 1'b1;
    pc = 10'h2a5;
    fire = 8'h00;
    lvl = 8'h00;
    repeat (2) @(negedge core_clk_in);
    rst_in = 1'b0;
    chk({stack_pointer_high, stack_pointer_low, gie, flags}, 25'h0, "reset values");
    $display("test reset done");
    op(9'h080, 8'h80);
    chk({stack_pointer_high, stack_pointer_low}, 16'h0080, "pointer write");
    op(9'h001, 8'h00);
    chk(stack_pointer_low, 8'h7f, "push");
    op(9'h002, 8'h00);
    chk(stack_pointer_low, 8'h80, "pop");
    op(9'h004, 8'h00);
    chk(stack_pointer_low, 8'h7e, "call");
    op(9'h008, 8'h00);
    chk(stack_pointer_low, 8'h80, "return");
    $display("test pointer done");
    fire_src(8'h24);
    chk(flags, 8'h24, "held flags");
    op(9'h100, 8'h00);
    chk(flags, 8'h24, "zero write");
    op(9'h100, 8'h20);
    chk(flags, 8'h04, "one write");
    fire_src(8'h20);
    // Level request that vanishes while masked must not be served
    lvl = 8'h02;
    repeat (4) @(negedge core_clk_in);
    lvl = 8'h00;
    repeat (4) @(negedge core_clk_in);
    cmd.enable = 8'h2e;
    op(9'h020, 8'h00);
    chk({gie, busy}, 2'b10, "after unmask");
    take(3'h2, 4);
    leave();
    take(3'h5, 4);
    leave();
    $display("test entry done");
    // Let the post-exit instruction retire so only insn_done, then cli, can block
    @(negedge core_clk_in);
    cmd.insn_done = 1'b0;
    fire_src(8'h08);
    chk(busy, 1'b0, "multi-cycle insn");
    @(negedge core_clk_in);
    cmd.insn_done = 1'b1;
    cmd.cli = 1'b1;
    @(negedge core_clk_in);
    cmd.cli = 1'b0;
    repeat (4) @(negedge core_clk_in);
    chk({gie, busy, flags}, 10'h008, "mask same cycle");
    cmd.sleeping = 1'b1;
    op(9'h020, 8'h00);
    take(3'h3, 8);
    cmd.sleeping = 1'b0;
    $display("test mask and wake done");
    results();
  end
endmodule
